// file: core/flash_status_pkg.sv
package flash_status_pkg;

   // Poll-byte bit positions on the data lines.
   localparam int unsigned POS_DATA_POLL    = 7;
   localparam int unsigned POS_TOGGLE_ONE   = 6;
   localparam int unsigned POS_TIMING_LIMIT = 5;
   localparam int unsigned POS_RSV_HIGH     = 4;
   localparam int unsigned POS_ERASE_WINDOW = 3;
   localparam int unsigned POS_TOGGLE_TWO   = 2;
   localparam int unsigned POS_BUFFER_ABORT = 1;
   localparam int unsigned POS_RSV_LOW      = 0;

   // Operation status byte bit positions.
   localparam int unsigned POS_SR_VALID      = 7;
   localparam int unsigned POS_SR_ERASE_ERR  = 5;
   localparam int unsigned POS_SR_PROG_ERR   = 4;

   // Mask that drops the two reserved poll bits.
   localparam logic [7:0] POLL_MASK = 8'hee;

   // Command bytes and the unlock address pair.
   localparam logic [7:0]  CMD_RESET        = 8'hf0;
   localparam logic [7:0]  CMD_STATUS_READ  = 8'h70;
   localparam logic [7:0]  CMD_STATUS_CLEAR = 8'h71;
   localparam logic [7:0]  CMD_UNLOCK_1     = 8'haa;
   localparam logic [7:0]  CMD_UNLOCK_2     = 8'h55;
   localparam logic [7:0]  CMD_ABORT_RESET  = 8'hf0;
   localparam logic [22:0] ADDR_CMD         = 23'h000555;
   localparam logic [22:0] ADDR_UNLOCK_2    = 23'h0002aa;

   // Bus cycle timing at 50 MHz.
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned ACCESS_TIME_NS  = 70;
   localparam int unsigned ACCESS_CYCLES   = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WRITE_PULSE_NS  = 40;
   localparam int unsigned WRITE_CYCLES    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_RECOVERY_US = 30;
   localparam int unsigned RESET_RECOVERY_CYCLES = RESET_RECOVERY_US * 1000 / CLK_PERIOD_NS;
   localparam logic [3:0] BUS_CNT_ONE = 4'h1;

   // Verdicts reported to the user.
   typedef enum logic [2:0] {
      VERDICT_NONE    = 3'h0,
      VERDICT_DONE    = 3'h1,
      VERDICT_TIMEOUT = 3'h2,
      VERDICT_ABORT   = 3'h3,
      VERDICT_OP_ERR  = 3'h4
   } verdict_t;

endpackage

// file: core/flash_bus_cycle.sv
`timescale 1ns/1ns
// Runs one asynchronous read or write cycle on the flash pins.
module flash_bus_cycle
   import flash_status_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        start_in,
   input  wire logic        write_in,
   input  wire logic [22:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic [7:0]  dq_sync_in,
   output logic             busy_out,
   output logic             done_out,
   output logic [7:0]       rdata_out,
   output logic [22:0]      flash_addr_out,
   output logic [7:0]       flash_dq_out,
   output logic             flash_dq_oe_out,
   output logic             flash_ce_n_out,
   output logic             flash_oe_n_out,
   output logic             flash_we_n_out
);

   logic [3:0] count;
   logic       is_write;
   wire        last_beat = (count == BUS_CNT_ONE);
   wire [3:0]  load_count = write_in ? 4'(WRITE_CYCLES) : 4'(ACCESS_CYCLES + 2);

   // Strobe held for the cycle length; a read samples two cycles after access time
   // so the three-flop input path has settled.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count           <= 4'h0;
         is_write        <= 1'b0;
         busy_out        <= 1'b0;
         done_out        <= 1'b0;
         rdata_out       <= 8'h00;
         flash_addr_out  <= 23'h000000;
         flash_dq_out    <= 8'h00;
         flash_dq_oe_out <= 1'b0;
         flash_ce_n_out  <= 1'b1;
         flash_oe_n_out  <= 1'b1;
         flash_we_n_out  <= 1'b1;
      end else begin
         done_out <= 1'b0;
         if (!busy_out && start_in) begin
            count           <= load_count;
            is_write        <= write_in;
            busy_out        <= 1'b1;
            flash_addr_out  <= addr_in;
            flash_dq_out    <= wdata_in;
            flash_dq_oe_out <= write_in;
            flash_ce_n_out  <= 1'b0;
            flash_oe_n_out  <= write_in;
            flash_we_n_out  <= !write_in;
         end else if (busy_out) begin
            count <= count - 4'h1;
            if (last_beat) begin
               busy_out        <= 1'b0;
               done_out        <= 1'b1;
               flash_ce_n_out  <= 1'b1;
               flash_oe_n_out  <= 1'b1;
               flash_we_n_out  <= 1'b1;
               flash_dq_oe_out <= 1'b0;
               if (!is_write) begin
                  rdata_out <= dq_sync_in;
               end
            end
         end
      end
   end

endmodule

// file: core/flash_status_host.sv
`timescale 1ns/1ns
// Functional notes
// - After timing failure, host writes reset command.
// - Host may skip window flag if fast.
// - Host checks window flag around each erase.
// - After abort, host sends abort-reset sequence.
// - Host polls a valid, last-loaded address.
// - Only reset or status clear ends error.
// - Host masks reserved poll bits.
module flash_status_host
   import flash_status_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        poll_start_in,
   input  wire logic [22:0] poll_addr_in,
   input  wire logic [7:0]  expect_data_in,
   input  wire logic        erase_window_check_in,
   input  wire logic [7:0]  flash_dq_in,
   input  wire logic        ready_busy_n_in,
   output logic             poll_busy_out,
   output logic             poll_done_out,
   output logic [2:0]       verdict_out,
   output logic [7:0]       operation_status_byte_out,
   output logic             erase_window_open_out,
   output logic             device_ready_out,
   output logic [22:0]      flash_addr_out,
   output logic [7:0]       flash_dq_out,
   output logic             flash_dq_oe_out,
   output logic             flash_ce_n_out,
   output logic             flash_oe_n_out,
   output logic             flash_we_n_out
);

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_READ_A   = 4'b0001,
      ST_READ_B   = 4'b0011,
      ST_RECHECK  = 4'b0010,
      ST_SR_CMD   = 4'b0110,
      ST_SR_READ  = 4'b0111,
      ST_CLR_1    = 4'b0101,
      ST_CLR_2    = 4'b0100,
      ST_CLR_3    = 4'b1100,
      ST_RECOVER  = 4'b1101,
      ST_FINISH   = 4'b1111
   } host_state_t;

   host_state_t state;
   host_state_t next_state;

   // Three-flop input paths; the first flop feeds only the second.
   logic [7:0] dq_s1, dq_s2, dq_s3;
   logic [2:0] rb_sync;
   logic       ready_level;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dq_s1   <= 8'h00;
         dq_s2   <= 8'h00;
         dq_s3   <= 8'h00;
         rb_sync <= 3'b000;
      end else begin
         dq_s1   <= flash_dq_in;
         dq_s2   <= dq_s1;
         dq_s3   <= dq_s2;
         rb_sync <= {rb_sync[1:0], ready_busy_n_in};
      end
   end

   // Ready level changes only once the second and third flops agree.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ready_level <= 1'b0;
      end else if (rb_sync[1] == rb_sync[2]) begin
         ready_level <= rb_sync[2];
      end
   end

   // Bus cycle engine.
   logic        cyc_start, cyc_write, cyc_busy, cyc_done;
   logic [22:0] cyc_addr;
   logic [7:0]  cyc_wdata, cyc_rdata;

   flash_bus_cycle u_cycle (
      .clk_in          (clk_in),
      .reset_n_in      (reset_n_in),
      .start_in        (cyc_start),
      .write_in        (cyc_write),
      .addr_in         (cyc_addr),
      .wdata_in        (cyc_wdata),
      .dq_sync_in      (dq_s3),
      .busy_out        (cyc_busy),
      .done_out        (cyc_done),
      .rdata_out       (cyc_rdata),
      .flash_addr_out  (flash_addr_out),
      .flash_dq_out    (flash_dq_out),
      .flash_dq_oe_out (flash_dq_oe_out),
      .flash_ce_n_out  (flash_ce_n_out),
      .flash_oe_n_out  (flash_oe_n_out),
      .flash_we_n_out  (flash_we_n_out)
   );

   logic [7:0]  first_read;
   logic [1:0]  clr_step;
   logic        clr_abort;
   logic        err_kind_abort;
   logic [31:0] recover_count;
   logic        issued;

   // Poll decisions on masked data.
   wire [7:0] masked_now  = cyc_rdata & POLL_MASK;
   wire [7:0] masked_prev = first_read & POLL_MASK;
   wire toggling  = masked_now[POS_TOGGLE_ONE] != masked_prev[POS_TOGGLE_ONE];
   wire poll_true = cyc_rdata[POS_DATA_POLL] == expect_data_in[POS_DATA_POLL];
   wire limit_hit = cyc_rdata[POS_TIMING_LIMIT];
   wire abort_hit = cyc_rdata[POS_BUFFER_ABORT];
   wire finished  = !toggling || poll_true;
   wire recover_done = (recover_count == 32'(RESET_RECOVERY_CYCLES));

   // Command bytes of the clearing sequences.
   wire [22:0] clr_addr = clr_abort && (clr_step == 2'h1) ? ADDR_UNLOCK_2 : ADDR_CMD;
   wire [7:0]  clr_data = !clr_abort ? CMD_RESET :
                          (clr_step == 2'h0) ? CMD_UNLOCK_1 :
                          (clr_step == 2'h1) ? CMD_UNLOCK_2 : CMD_ABORT_RESET;

   assign cyc_write = (state == ST_SR_CMD) || (state == ST_CLR_1);
   assign cyc_addr  = (state == ST_CLR_1) ? clr_addr : (state == ST_SR_CMD) ? ADDR_CMD
                                          : poll_addr_in;
   assign cyc_wdata = (state == ST_CLR_1) ? clr_data : CMD_STATUS_READ;
   assign cyc_start = !issued && !cyc_busy && ((state == ST_READ_A) || (state == ST_READ_B) ||
                      (state == ST_RECHECK) || (state == ST_SR_CMD) || (state == ST_SR_READ) ||
                      (state == ST_CLR_1));

   // Next state from the finished bus cycle.
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:    if (poll_start_in) next_state = ST_READ_A;
         ST_READ_A:  if (cyc_done) next_state = ST_READ_B;
         ST_READ_B: begin
            if (cyc_done) begin
               if (finished) next_state = ST_FINISH;
               else if (abort_hit) next_state = ST_SR_CMD;
               else if (limit_hit) next_state = ST_RECHECK;
               else next_state = ST_READ_A;
            end
         end
         ST_RECHECK: begin
            if (cyc_done) next_state = finished ? ST_FINISH : ST_SR_CMD;
         end
         ST_SR_CMD:  if (cyc_done) next_state = ST_SR_READ;
         ST_SR_READ: if (cyc_done) next_state = ST_CLR_1;
         ST_CLR_1: begin
            if (cyc_done) next_state = (!clr_abort || clr_step == 2'h2) ? ST_CLR_2 : ST_CLR_1;
         end
         ST_CLR_2:   next_state = ST_RECOVER;
         ST_RECOVER: if (ready_level || recover_done) next_state = ST_FINISH;
         ST_FINISH:  next_state = ST_IDLE;
         default:    next_state = ST_IDLE;
      endcase
   end

   // State and poll bookkeeping.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state          <= ST_IDLE;
         issued         <= 1'b0;
         first_read     <= 8'h00;
         clr_step       <= 2'h0;
         clr_abort      <= 1'b0;
         err_kind_abort <= 1'b0;
         recover_count  <= 32'h0;
      end else begin
         state  <= next_state;
         issued <= cyc_start ? 1'b1 : (cyc_done ? 1'b0 : issued);
         if (state == ST_IDLE) begin
            clr_step <= 2'h0;
            err_kind_abort <= 1'b0;
         end
         if (cyc_done && (state != ST_SR_READ) && (state != ST_CLR_1)) begin
            first_read <= cyc_rdata;
         end
         if (cyc_done && state == ST_READ_B && !finished && abort_hit) begin
            err_kind_abort <= 1'b1;
         end
         if (state == ST_SR_CMD) begin
            clr_abort <= err_kind_abort;
         end
         if (cyc_done && state == ST_CLR_1) begin
            clr_step <= clr_step + 2'h1;
         end
         recover_count <= (state == ST_RECOVER) ? recover_count + 32'h1 : 32'h0;
      end
   end

   // User outputs, all registered.
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         poll_busy_out             <= 1'b0;
         poll_done_out             <= 1'b0;
         verdict_out               <= VERDICT_NONE;
         operation_status_byte_out <= 8'h00;
         erase_window_open_out     <= 1'b0;
         device_ready_out          <= 1'b0;
      end else begin
         poll_busy_out    <= (next_state != ST_IDLE);
         poll_done_out    <= (state == ST_FINISH);
         device_ready_out <= ready_level;
         if (cyc_done && state == ST_SR_READ) begin
            operation_status_byte_out <= cyc_rdata;
            verdict_out <= err_kind_abort ? VERDICT_ABORT :
                           cyc_rdata[POS_SR_VALID] ? VERDICT_OP_ERR : VERDICT_TIMEOUT;
         end else if (state == ST_READ_A && poll_start_in == 1'b0 && cyc_start) begin
            verdict_out <= VERDICT_NONE;
         end else if (state != ST_RECOVER && next_state == ST_FINISH) begin
            verdict_out <= VERDICT_DONE;
         end
         // Window flag low: more sector erase commands may follow.
         if (cyc_done && erase_window_check_in && state == ST_READ_A) begin
            erase_window_open_out <= !cyc_rdata[POS_ERASE_WINDOW];
         end
      end
   end

   // Host-side checks.
   chk_clear_after_error: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state == ST_SR_READ && cyc_done) |=> state == ST_CLR_1)
      else $error("Error not followed by clearing");
   chk_mask_reserved: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      masked_now[POS_RSV_HIGH] == 1'b0 && masked_now[POS_RSV_LOW] == 1'b0)
      else $error("Reserved poll bits not masked");
   chk_done_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      poll_done_out |=> !poll_done_out)
      else $error("Done longer than one cycle");
   chk_pins_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state == ST_IDLE && !cyc_busy) |-> (flash_ce_n_out && !flash_dq_oe_out))
      else $error("Bus active while idle");
   chk_abort_seq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state == ST_CLR_1 && clr_abort && clr_step == 2'h0) |-> cyc_wdata == CMD_UNLOCK_1)
      else $error("Abort reset lacks unlock");
   chk_reset_cmd: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state == ST_CLR_1 && !clr_abort) |-> cyc_wdata == CMD_RESET)
      else $error("Timeout clear not reset command");
   chk_recover_bound: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      state == ST_RECOVER |-> recover_count <= 32'(RESET_RECOVERY_CYCLES))
      else $error("Recovery wait overran");
   chk_two_reads: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (state == ST_READ_A && cyc_done) |=> state == ST_READ_B)
      else $error("Toggle check skipped second read");
   cov_finish: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      state == ST_FINISH && verdict_out == VERDICT_DONE);
   cov_abort: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      state == ST_CLR_1 && clr_abort);
   cov_recover: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      state == ST_RECOVER && ready_level);

endmodule

// file: test/flash_device_model.sv
`timescale 1ns/1ns
// Behavioural flash device that answers asynchronous bus cycles with poll status.
// Modes: 0 ready, 1 program busy, 2 operation error, 3 buffer abort.
module flash_device_model
   import flash_status_pkg::*;
(
   input  wire logic        load_in,
   input  wire logic [1:0]  mode_in,
   input  wire logic [3:0]  reads_in,
   input  wire logic [7:0]  data_in,
   input  wire logic [22:0] addr_in,
   input  wire logic [7:0]  dq_in,
   input  wire logic        ce_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   output logic [7:0]       dq_out,
   output logic             ready_busy_n_out
);
   localparam int RECOVERY_NS = 2000;
   logic [1:0] state = 2'h0;
   logic [3:0] left = 4'h0;
   logic       tog = 1'b0;
   logic       sr_sel = 1'b0;
   logic [1:0] unl = 2'h0;
   logic [7:0] last = 8'h00;
   logic [7:0] busy_byte;
   logic [7:0] err_byte;
   logic [7:0] abort_byte;
   logic [7:0] sr_byte;
   logic [7:0] drive;
   wire        read_en = !ce_n_in && !oe_n_in;
   wire        write_en = !ce_n_in && !we_n_in;
   // The acceptance window stays open (flag 0) until only two busy reads remain.
   wire        window_shut = (left <= 4'h2);

   // Status overlays; reserved poll bits read as 0.
   assign busy_byte  = {~data_in[7], tog, 2'h0, window_shut, 3'h0};
   assign err_byte   = {~data_in[7], tog, 1'b1, 1'b0, 1'b1, tog, 2'h0};
   assign abort_byte = {~data_in[7], tog, 4'h0, 2'h2};
   assign sr_byte    = (state == 2'h2) ? 8'h90 : (state == 2'h3) ? 8'h98 : 8'h80;
   assign drive = sr_sel ? sr_byte : (state == 2'h0) ? data_in :
                  (state == 2'h1) ? busy_byte : (state == 2'h2) ? err_byte : abort_byte;
   // Released lines show the inverse of the last byte so stale data never matches.
   assign dq_out = read_en ? drive : ~last;
   assign ready_busy_n_out = (state == 2'h0);

   // A new operation starts when the bench loads a mode.
   always @(posedge load_in) begin
      state = mode_in;
      left = reads_in;
      tog = 1'b0;
      sr_sel = 1'b0;
      unl = 2'h0;
   end

   // At the end of each read while not ready the toggle bit flips and program progress advances.
   always @(negedge read_en) begin
      last = drive;
      sr_sel = 1'b0;
      if (state != 2'h0) tog = ~tog;
      if (state == 2'h1) begin
         if (left <= 4'h1) state = 2'h0;
         else left = left - 4'h1;
      end
   end

   // Command decode; status read and unlock are honoured in any mode, clear only in modes 2 and 3, reset in mode 2, abort reset in mode 3 after unlock.
   always @(negedge write_en) begin
      if (dq_in == CMD_STATUS_READ && addr_in == ADDR_CMD) sr_sel = 1'b1;
      else if (dq_in == CMD_STATUS_CLEAR && state[1]) state = 2'h0;
      else if (dq_in == CMD_UNLOCK_1 && addr_in == ADDR_CMD) unl = 2'h1;
      else if (dq_in == CMD_UNLOCK_2 && addr_in == ADDR_UNLOCK_2 && unl == 2'h1) unl = 2'h2;
      else if (dq_in == CMD_RESET && state == 2'h2) fork #RECOVERY_NS state = 2'h0; join_none
      else if (dq_in == CMD_ABORT_RESET && state == 2'h3 && unl == 2'h2) state = 2'h0;
      if (dq_in == CMD_RESET) unl = 2'h0;
   end
endmodule

// file: test/flash_op_status_and_errors_test.sv
`timescale 1ns/1ns
`define CHECK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("CHECK FAILED at %0t: %s", $time, msg); end end

// Runs status polls against the device model and checks the verdicts.
module flash_op_status_and_errors_test import flash_status_pkg::*;;
   typedef struct packed {
      logic [1:0] mode;
      logic [3:0] reads;
      logic [7:0] data;
      logic       ewc;
      logic [2:0] verdict;
      logic       win_open;
      logic [7:0] sr;
      logic [7:0] srm;
   } row_t;
   row_t rows [4] = '{
      '{2'h0, 4'h0, 8'h5a, 1'b0, 3'h1, 1'b0, 8'h00, 8'hff},
      '{2'h1, 4'h3, 8'ha5, 1'b1, 3'h1, 1'b0, 8'h00, 8'hff},
      '{2'h2, 4'h0, 8'h00, 1'b0, 3'h4, 1'b0, 8'h90, 8'hbe},
      '{2'h3, 4'h0, 8'h3c, 1'b0, 3'h3, 1'b0, 8'h80, 8'h80}};
   int          n_mismatch = 0;
   int          num_checks = 0;
   logic        clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        poll_start_in = 1'b0;
   logic        erase_window_check_in = 1'b0;
   logic        load = 1'b0;
   logic [22:0] poll_addr_in = 23'h001000;
   logic [7:0]  expect_data_in = 8'h00;
   logic [1:0]  mode = 2'h0;
   logic [3:0]  reads = 4'h0;
   wire  [7:0]  dq;
   wire         ready_busy_n;
   logic        poll_busy_out, poll_done_out, erase_window_open_out, device_ready_out;
   logic [2:0]  verdict_out;
   logic [7:0]  operation_status_byte_out, flash_dq_out;
   logic [22:0] flash_addr_out;
   logic        flash_dq_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out;

   always #10 clk_in = ~clk_in;

   flash_status_host i_flash_status_host (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .poll_start_in(poll_start_in), .poll_addr_in(poll_addr_in),
      .expect_data_in(expect_data_in), .erase_window_check_in(erase_window_check_in),
      .flash_dq_in(dq), .ready_busy_n_in(ready_busy_n), .poll_busy_out(poll_busy_out),
      .poll_done_out(poll_done_out), .verdict_out(verdict_out),
      .operation_status_byte_out(operation_status_byte_out),
      .erase_window_open_out(erase_window_open_out), .device_ready_out(device_ready_out),
      .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
      .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out),
      .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out));

   flash_device_model i_flash_device_model (.load_in(load), .mode_in(mode), .reads_in(reads),
      .data_in(expect_data_in), .addr_in(flash_addr_out), .dq_in(flash_dq_out),
      .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
      .dq_out(dq), .ready_busy_n_out(ready_busy_n));

   // Watches the strobes: reads address the polled location, writes drive the data lines.
   always @(negedge clk_in) begin
      if (reset_n_in && !flash_oe_n_out)
         `CHECK(flash_addr_out, poll_addr_in, "read at polled address")
      if (reset_n_in && !flash_we_n_out)
         `CHECK({flash_dq_oe_out, flash_oe_n_out}, 2'b11, "write drives data")
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Loads a new operation into the device and sets the matching poll inputs.
   task automatic load_device(input logic [1:0] m, input logic [3:0] r, input logic [7:0] d,
                              input logic ewc);
      @(posedge clk_in);
      #2 mode = m;
      reads = r;
      expect_data_in = d;
      erase_window_check_in = ewc;
      load = 1'b1;
      @(posedge clk_in);
      #2 load = 1'b0;
   endtask

   // One-cycle start request in the idle state.
   task automatic start_poll();
      @(posedge clk_in);
      #2 poll_start_in = 1'b1;
      @(posedge clk_in);
      #2 poll_start_in = 1'b0;
   endtask

   // Waits for the done pulse under a bound, then lets the verdict settle.
   task automatic wait_done();
      int n;
      n = 0;
      while (poll_done_out !== 1'b1) begin
         @(posedge clk_in);
         #1 n++;
         if (n > 5000) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: poll never finished", $time);
            finish_test();
         end
      end
      @(posedge clk_in);
      #1;
   endtask

   initial begin
      int n;
      repeat (3) @(posedge clk_in);
      #2 reset_n_in = 1'b1;
      `CHECK(flash_ce_n_out, 1'b1, "chip select idle after reset")
      foreach (rows[i]) begin
         load_device(rows[i].mode, rows[i].reads, rows[i].data, rows[i].ewc);
         start_poll();
         wait_done();
         `CHECK(verdict_out, rows[i].verdict, "poll verdict")
         if (rows[i].ewc) `CHECK(erase_window_open_out, rows[i].win_open, "window open")
         `CHECK(operation_status_byte_out & rows[i].srm, rows[i].sr, "status byte")
         repeat (10) @(posedge clk_in);
         #1 `CHECK(device_ready_out, 1'b1, "device ready after poll")
      end
      // A second start while a poll runs must be ignored.
      load_device(2'h1, 4'h6, 8'h81, 1'b1);
      start_poll();
      @(posedge clk_in);
      #2 poll_start_in = 1'b1;
      @(posedge clk_in);
      #2 poll_start_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1 `CHECK(device_ready_out, 1'b0, "busy while programming")
      // The first read of the poll still sees the acceptance window open.
      repeat (4) @(posedge clk_in);
      #1 `CHECK(erase_window_open_out, 1'b1, "window open early")
      n = 0;
      for (int k = 0; k < 3000 && poll_busy_out !== 1'b0; k++) begin
         @(posedge clk_in);
         #1 if (poll_done_out === 1'b1) n++;
      end
      if (poll_busy_out !== 1'b0) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: poll never went idle", $time);
         finish_test();
      end
      repeat (20) begin
         @(posedge clk_in);
         #1 if (poll_done_out === 1'b1) n++;
      end
      `CHECK(n, 1, "one poll per start")
      `CHECK(verdict_out, 3'h1, "program done")
      // Reset in mid-poll of an error; the error stays until the host clears it.
      load_device(2'h2, 4'h0, 8'h80, 1'b0);
      start_poll();
      repeat (10) @(posedge clk_in);
      #2 reset_n_in = 1'b0;
      #1 `CHECK(poll_busy_out, 1'b0, "poll dropped by reset")
      `CHECK(flash_ce_n_out, 1'b1, "strobe released by reset")
      `CHECK(verdict_out, 3'h0, "verdict cleared by reset")
      repeat (3) @(posedge clk_in);
      #2 reset_n_in = 1'b1;
      repeat (10) @(posedge clk_in);
      #1 `CHECK(device_ready_out, 1'b0, "error keeps device busy")
      start_poll();
      wait_done();
      `CHECK(verdict_out, 3'h4, "error found after reset")
      repeat (10) @(posedge clk_in);
      #1 `CHECK(device_ready_out, 1'b1, "error cleared")
      finish_test();
   end
endmodule
